//--- fifo_port_host.sv
// host that drives the fifo handshake port and its processor bus port
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
// Function
// - host pulls valid input low only while its byte is on the lines.
// - host raises the same input high once it has taken the byte.
// - host holds third line high when ready for the next byte.
// - clear line is bidirectional; driving it low discards all bytes.
// - direction line is bidirectional; high flows into port two.
// - DMA controller asserts grant low for each granted transfer.
// - host asserts read strobe low; device then drives the data lines.
// - host asserts write strobe low to write a byte.
// - host holds chip enable low for an access; else strobes ignored.
// - control/data select high marks control, low marks data byte.
// - host asserts acknowledge low to acknowledge a pending interrupt.
// - chain enable passes from higher to lower priority neighbour.
module fifo_port_host (
    input wire logic clock,
    input wire logic rst,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] hs_data_in,
    output logic [7:0] hs_data_out,
    output logic hs_data_oe,
    output logic output_enable_n,
    input wire logic ready_or_available_out,
    output logic valid_or_accepted_in,
    input wire logic accepted_or_listener_ready_in,
    output logic accepted_or_listener_ready_out,
    output logic accepted_or_listener_ready_oe,
    input wire logic empty,
    input wire logic clear_n_in,
    output logic clear_n_out,
    output logic clear_n_oe,
    input wire logic data_dir_in,
    output logic data_dir_out,
    output logic data_dir_oe,
    output logic gp_input_bit0,
    input wire logic gp_output_bit1,
    input wire logic gp_output_bit3,
    input wire logic [7:0] bus_data_in,
    output logic [7:0] bus_data_out,
    output logic bus_data_oe,
    input wire logic req_wait_n,
    output logic dma_grant_n,
    output logic read_n,
    output logic write_n,
    output logic chip_enable_n,
    output logic control_select,
    output logic irq_acknowledge_n,
    output logic chain_enable_in,
    input wire logic chain_enable_out,
    input wire logic irq_n
);

    function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
        return a == r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    sync_if #(.W(fifo_host_pkg::SY_W)) sy ();
    logic [fifo_host_pkg::SY_W-1:0] s;

    assign sy.raw = {bus_data_in, hs_data_in, irq_n, chain_enable_out,
                     req_wait_n, gp_output_bit3, gp_output_bit1, data_dir_in,
                     clear_n_in, empty, accepted_or_listener_ready_in,
                     ready_or_available_out};
    assign s = sy.clean;

    pin_sync u_sync (
        .clock(clock),
        .rst(rst),
        .port(sy)
    );

    logic rfd_s;
    logic dac_s;
    logic [7:0] hs_data_s;
    logic [7:0] bus_data_s;
    assign rfd_s = s[fifo_host_pkg::SY_RFD];
    assign dac_s = s[fifo_host_pkg::SY_DAC];
    assign hs_data_s = s[fifo_host_pkg::SY_HS_DATA +: 8];
    assign bus_data_s = s[fifo_host_pkg::SY_BUS_DATA +: 8];

    ////////////////////////////////////////////////////////////////////////
    // avalon slave and control register
    logic resp_r;
    logic resp_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [5:0] ctrl_r;
    logic [5:0] ctrl_nxt;
    logic [31:0] status;
    logic blocked;
    logic wr_take;
    logic rd_take;
    logic tx_wr;
    logic rx_rd;
    logic cmd_go;
    logic clear_go;
    logic tx_busy_r;
    logic rx_valid_r;
    logic [7:0] rx_byte_r;
    logic [7:0] bus_rdata_r;
    fifo_host_pkg::bus_state_t bus_r;

    assign wr_take = avs_write && resp_r;
    assign rd_take = avs_read && resp_r;
    assign tx_wr = wr_take && hit(avs_address, fifo_host_pkg::REG_TX);
    assign rx_rd = rd_take && hit(avs_address, fifo_host_pkg::REG_RX);
    assign cmd_go = wr_take && hit(avs_address, fifo_host_pkg::REG_BUS_CMD);
    assign clear_go = wr_take && hit(avs_address, fifo_host_pkg::REG_CTRL)
                      && avs_writedata[fifo_host_pkg::CTRL_CLEAR];
    assign avs_waitrequest = (avs_read || avs_write) && !resp_r;
    assign avs_readdata = rdata_r;

    always_comb begin
        status = 32'h0000_0000;
        status[fifo_host_pkg::ST_TX_BUSY] = tx_busy_r;
        status[fifo_host_pkg::ST_RX_VALID] = rx_valid_r;
        status[fifo_host_pkg::ST_EMPTY] = s[fifo_host_pkg::SY_EMPTY];
        status[fifo_host_pkg::ST_CLEAR_N] = s[fifo_host_pkg::SY_CLEAR_N];
        status[fifo_host_pkg::ST_DATA_DIR] = s[fifo_host_pkg::SY_DIR];
        status[fifo_host_pkg::ST_GP1] = s[fifo_host_pkg::SY_GP1];
        status[fifo_host_pkg::ST_GP3] = s[fifo_host_pkg::SY_GP3];
        status[fifo_host_pkg::ST_IRQ] = !s[fifo_host_pkg::SY_INT_N];
        status[fifo_host_pkg::ST_CHAIN_OUT] = s[fifo_host_pkg::SY_CHAIN];
        status[fifo_host_pkg::ST_REQ_WAIT_N] = s[fifo_host_pkg::SY_REQ_N];
        status[fifo_host_pkg::ST_BUS_BUSY] = bus_r != fifo_host_pkg::BUS_IDLE;
    end

    always_comb begin
        // a byte write waits while the previous one is still pending
        blocked = avs_write && ((hit(avs_address, fifo_host_pkg::REG_TX)
                  && tx_busy_r) || (hit(avs_address, fifo_host_pkg::REG_BUS_CMD)
                  && bus_r != fifo_host_pkg::BUS_IDLE));
        resp_nxt = (avs_read || avs_write) && !resp_r && !blocked;
        rdata_nxt = rdata_r;
        if (resp_nxt && avs_read) begin
            case (avs_address)
                fifo_host_pkg::REG_CTRL: rdata_nxt = {26'h0, ctrl_r};
                fifo_host_pkg::REG_STATUS: rdata_nxt = status;
                fifo_host_pkg::REG_RX: rdata_nxt = {24'h0, rx_byte_r};
                fifo_host_pkg::REG_BUS_RDATA: rdata_nxt = {24'h0, bus_rdata_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        ctrl_nxt = ctrl_r;
        if (wr_take && hit(avs_address, fifo_host_pkg::REG_CTRL)) begin
            ctrl_nxt = avs_writedata[5:0];
            ctrl_nxt[fifo_host_pkg::CTRL_CLEAR] = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            resp_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            ctrl_r <= fifo_host_pkg::CTRL_RESET;
        end else begin
            resp_r <= resp_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    logic hs_en;
    logic hs_send;
    assign hs_en = ctrl_r[fifo_host_pkg::CTRL_HS_EN];
    assign hs_send = ctrl_r[fifo_host_pkg::CTRL_HS_SEND];
    assign data_dir_oe = ctrl_r[fifo_host_pkg::CTRL_DIR_DRIVE];
    assign data_dir_out = hs_send;
    assign gp_input_bit0 = ctrl_r[fifo_host_pkg::CTRL_GP_IN];
    assign chain_enable_in = ctrl_r[fifo_host_pkg::CTRL_CHAIN];

    ////////////////////////////////////////////////////////////////////////
    // clear pulse: drives the line low, otherwise leaves it to the device
    logic [fifo_host_pkg::CNT_W-1:0] clr_cnt_r;
    logic [fifo_host_pkg::CNT_W-1:0] clr_cnt_nxt;

    always_comb begin
        clr_cnt_nxt = clr_cnt_r;
        if (clear_go) begin
            clr_cnt_nxt = fifo_host_pkg::CNT_W'(fifo_host_pkg::CLEAR_CYCLES);
        end else if (clr_cnt_r != '0) begin
            clr_cnt_nxt = clr_cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clr_cnt_r <= '0;
        end else begin
            clr_cnt_r <= clr_cnt_nxt;
        end
    end

    assign clear_n_out = 1'b0;
    assign clear_n_oe = clr_cnt_r != '0;

    ////////////////////////////////////////////////////////////////////////
    // three-wire handshake peripheral
    fifo_host_pkg::hs_state_t hs_r;
    fifo_host_pkg::hs_state_t hs_nxt;
    logic [fifo_host_pkg::CNT_W-1:0] hs_cnt_r;
    logic [fifo_host_pkg::CNT_W-1:0] hs_cnt_nxt;
    logic [7:0] tx_byte_r;
    logic [7:0] tx_byte_nxt;
    logic tx_busy_nxt;
    logic rx_valid_nxt;
    logic [7:0] rx_byte_nxt;
    logic voa_r;
    logic voa_nxt;
    logic lr_r;
    logic lr_nxt;
    logic lr_oe_r;
    logic lr_oe_nxt;
    logic hs_oe_r;
    logic hs_oe_nxt;
    logic oe_n_r;
    logic oe_n_nxt;

    always_comb begin
        hs_nxt = hs_r;
        hs_cnt_nxt = hs_cnt_r;
        tx_byte_nxt = tx_wr ? avs_writedata[7:0] : tx_byte_r;
        tx_busy_nxt = tx_busy_r || tx_wr;
        rx_byte_nxt = rx_byte_r;
        rx_valid_nxt = rx_valid_r && !rx_rd;
        case (hs_r)
            fifo_host_pkg::HS_IDLE: begin
                if (hs_en && hs_send && tx_busy_r && rfd_s) begin
                    hs_nxt = fifo_host_pkg::HS_SETUP;
                    hs_cnt_nxt =
                        fifo_host_pkg::CNT_W'(fifo_host_pkg::SETUP_CYCLES);
                end else if (hs_en && !hs_send) begin
                    hs_nxt = fifo_host_pkg::HS_RX_READY;
                end
            end
            fifo_host_pkg::HS_SETUP: begin
                // byte settles on the lines before valid falls
                if (hs_cnt_r <= 1) begin
                    hs_nxt = fifo_host_pkg::HS_VALID;
                end else begin
                    hs_cnt_nxt = hs_cnt_r - 1'b1;
                end
            end
            fifo_host_pkg::HS_VALID: begin
                if (dac_s) begin
                    hs_nxt = fifo_host_pkg::HS_RELEASE;
                    tx_busy_nxt = 1'b0;
                end
            end
            fifo_host_pkg::HS_RELEASE: begin
                if (!dac_s) begin
                    hs_nxt = fifo_host_pkg::HS_IDLE;
                end
            end
            fifo_host_pkg::HS_RX_READY: begin
                if (!hs_en || hs_send) begin
                    hs_nxt = fifo_host_pkg::HS_IDLE;
                end else if (lr_r && !rfd_s) begin
                    hs_nxt = fifo_host_pkg::HS_RX_ACCEPT;
                    rx_byte_nxt = hs_data_s;
                    rx_valid_nxt = 1'b1; // set wins over a same-cycle read
                end
            end
            fifo_host_pkg::HS_RX_ACCEPT: begin
                if (rfd_s) begin
                    hs_nxt = fifo_host_pkg::HS_IDLE;
                end
            end
            default: hs_nxt = fifo_host_pkg::HS_IDLE;
        endcase
        // pin levels follow the state being entered
        hs_oe_nxt = hs_nxt == fifo_host_pkg::HS_SETUP
                    || hs_nxt == fifo_host_pkg::HS_VALID;
        voa_nxt = hs_send; // idle level differs per direction
        if (hs_nxt == fifo_host_pkg::HS_VALID) begin
            voa_nxt = 1'b0;
        end else if (hs_nxt == fifo_host_pkg::HS_RX_ACCEPT) begin
            voa_nxt = 1'b1;
        end else if (hs_nxt == fifo_host_pkg::HS_RX_READY) begin
            voa_nxt = 1'b0;
        end
        // listener ready only with room, so the device stalls on a full host
        lr_nxt = hs_nxt == fifo_host_pkg::HS_RX_READY && !rx_valid_nxt
                 && !(rfd_s == 1'b0 && !lr_r);
        lr_oe_nxt = hs_en && !hs_send;
        oe_n_nxt = !(hs_en && !hs_send);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hs_r <= fifo_host_pkg::HS_IDLE;
            hs_cnt_r <= '0;
            tx_byte_r <= 8'h00;
            tx_busy_r <= 1'b0;
            rx_byte_r <= 8'h00;
            rx_valid_r <= 1'b0;
            voa_r <= 1'b0;
            lr_r <= 1'b0;
            lr_oe_r <= 1'b0;
            hs_oe_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else begin
            hs_r <= hs_nxt;
            hs_cnt_r <= hs_cnt_nxt;
            tx_byte_r <= tx_byte_nxt;
            tx_busy_r <= tx_busy_nxt;
            rx_byte_r <= rx_byte_nxt;
            rx_valid_r <= rx_valid_nxt;
            voa_r <= voa_nxt;
            lr_r <= lr_nxt;
            lr_oe_r <= lr_oe_nxt;
            hs_oe_r <= hs_oe_nxt;
            oe_n_r <= oe_n_nxt;
        end
    end

    assign hs_data_out = tx_byte_r;
    assign hs_data_oe = hs_oe_r;
    assign valid_or_accepted_in = voa_r;
    assign accepted_or_listener_ready_out = lr_r;
    assign accepted_or_listener_ready_oe = lr_oe_r;
    assign output_enable_n = oe_n_r;

    ////////////////////////////////////////////////////////////////////////
    // processor bus master, with dma and interrupt acknowledge cycles
    fifo_host_pkg::bus_state_t bus_nxt;
    logic [11:0] cmd_r;
    logic [11:0] cmd_nxt;
    logic [fifo_host_pkg::CNT_W-1:0] bcnt_r;
    logic [fifo_host_pkg::CNT_W-1:0] bcnt_nxt;
    logic [7:0] bus_rdata_nxt;
    logic [6:0] pins_r;
    logic [6:0] pins_nxt;
    logic sel;
    logic strobe;
    logic is_rd;
    logic is_dma;
    logic is_ack;

    assign is_rd = cmd_nxt[fifo_host_pkg::CMD_READ]
                   || cmd_nxt[fifo_host_pkg::CMD_IRQ_ACKNOWLEDGE_N];
    assign is_dma = cmd_nxt[fifo_host_pkg::CMD_DMA];
    assign is_ack = cmd_nxt[fifo_host_pkg::CMD_IRQ_ACKNOWLEDGE_N];

    always_comb begin
        bus_nxt = bus_r;
        bcnt_nxt = bcnt_r;
        cmd_nxt = cmd_go ? avs_writedata[11:0] : cmd_r;
        bus_rdata_nxt = bus_rdata_r;
        case (bus_r)
            fifo_host_pkg::BUS_IDLE: begin
                if (cmd_go) begin
                    bus_nxt = avs_writedata[fifo_host_pkg::CMD_DMA]
                              ? fifo_host_pkg::BUS_REQ
                              : fifo_host_pkg::BUS_SETUP;
                    bcnt_nxt =
                        fifo_host_pkg::CNT_W'(fifo_host_pkg::SETUP_CYCLES);
                end
            end
            fifo_host_pkg::BUS_REQ: begin
                if (!s[fifo_host_pkg::SY_REQ_N]) begin
                    bus_nxt = fifo_host_pkg::BUS_SETUP;
                end
            end
            fifo_host_pkg::BUS_SETUP: begin
                if (bcnt_r <= 1) begin
                    bus_nxt = fifo_host_pkg::BUS_STROBE;
                    bcnt_nxt =
                        fifo_host_pkg::CNT_W'(fifo_host_pkg::STROBE_CYCLES);
                end else begin
                    bcnt_nxt = bcnt_r - 1'b1;
                end
            end
            fifo_host_pkg::BUS_STROBE: begin
                if (bcnt_r > 1) begin
                    bcnt_nxt = bcnt_r - 1'b1;
                end else if (is_dma || s[fifo_host_pkg::SY_REQ_N]) begin
                    // a cpu cycle is stretched while wait is held low
                    bus_nxt = fifo_host_pkg::BUS_HOLD;
                    bcnt_nxt =
                        fifo_host_pkg::CNT_W'(fifo_host_pkg::SETUP_CYCLES);
                    if (is_rd) begin
                        bus_rdata_nxt = bus_data_s;
                    end
                end
            end
            fifo_host_pkg::BUS_HOLD: begin
                if (bcnt_r <= 1) begin
                    bus_nxt = fifo_host_pkg::BUS_IDLE;
                end else begin
                    bcnt_nxt = bcnt_r - 1'b1;
                end
            end
            default: bus_nxt = fifo_host_pkg::BUS_IDLE;
        endcase
        sel = bus_nxt == fifo_host_pkg::BUS_SETUP
              || bus_nxt == fifo_host_pkg::BUS_STROBE
              || bus_nxt == fifo_host_pkg::BUS_HOLD;
        strobe = bus_nxt == fifo_host_pkg::BUS_STROBE;
        // {oe, ack_n, grant_n, ce_n, cd, wr_n, rd_n}
        pins_nxt[0] = !(strobe && is_rd);
        pins_nxt[1] = !(strobe && !is_rd);
        pins_nxt[2] = sel && cmd_nxt[fifo_host_pkg::CMD_CTRL];
        pins_nxt[3] = !(sel && !is_dma && !is_ack);
        pins_nxt[4] = !(sel && is_dma);
        pins_nxt[5] = !(sel && is_ack);
        pins_nxt[6] = sel && !is_rd;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bus_r <= fifo_host_pkg::BUS_IDLE;
            bcnt_r <= '0;
            cmd_r <= 12'h000;
            bus_rdata_r <= 8'h00;
            pins_r <= 7'h3B;
        end else begin
            bus_r <= bus_nxt;
            bcnt_r <= bcnt_nxt;
            cmd_r <= cmd_nxt;
            bus_rdata_r <= bus_rdata_nxt;
            pins_r <= pins_nxt;
        end
    end

    assign read_n = pins_r[0];
    assign write_n = pins_r[1];
    assign control_select = pins_r[2];
    assign chip_enable_n = pins_r[3];
    assign dma_grant_n = pins_r[4];
    assign irq_acknowledge_n = pins_r[5];
    assign bus_data_oe = pins_r[6];
    assign bus_data_out = cmd_r[7:0];

endmodule // fifo_port_host

//--- fifo_host_pkg.sv
// constants, field layouts and state types of the fifo port host
package fifo_host_pkg;

    localparam int CLOCK_MHZ = 100;
    localparam int SETUP_NS = 20;
    localparam int STROBE_NS = 100;
    localparam int CLEAR_NS = 200;
    // least times, so round up to whole cycles
    localparam int SETUP_CYCLES = (SETUP_NS * CLOCK_MHZ + 999) / 1000;
    localparam int STROBE_CYCLES = (STROBE_NS * CLOCK_MHZ + 999) / 1000;
    localparam int CLEAR_CYCLES = (CLEAR_NS * CLOCK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;

    // avalon word addresses
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_TX = 3'h2;
    localparam logic [2:0] REG_RX = 3'h3;
    localparam logic [2:0] REG_BUS_CMD = 3'h4;
    localparam logic [2:0] REG_BUS_RDATA = 3'h5;

    // control register fields
    localparam int CTRL_HS_EN = 0;
    localparam int CTRL_HS_SEND = 1;
    localparam int CTRL_DIR_DRIVE = 2;
    localparam int CTRL_CLEAR = 3;
    localparam int CTRL_GP_IN = 4;
    localparam int CTRL_CHAIN = 5;
    localparam logic [5:0] CTRL_RESET = 6'h20;

    // bus command fields, data byte in bits 7:0
    localparam int CMD_READ = 8;
    localparam int CMD_CTRL = 9;
    localparam int CMD_DMA = 10;
    localparam int CMD_IRQ_ACKNOWLEDGE_N = 11;

    // status register fields
    localparam int ST_TX_BUSY = 0;
    localparam int ST_RX_VALID = 1;
    localparam int ST_EMPTY = 2;
    localparam int ST_CLEAR_N = 3;
    localparam int ST_DATA_DIR = 4;
    localparam int ST_GP1 = 5;
    localparam int ST_GP3 = 6;
    localparam int ST_IRQ = 7;
    localparam int ST_CHAIN_OUT = 8;
    localparam int ST_REQ_WAIT_N = 9;
    localparam int ST_BUS_BUSY = 10;

    // positions in the synchronised pin vector
    localparam int SY_RFD = 0;
    localparam int SY_DAC = 1;
    localparam int SY_EMPTY = 2;
    localparam int SY_CLEAR_N = 3;
    localparam int SY_DIR = 4;
    localparam int SY_GP1 = 5;
    localparam int SY_GP3 = 6;
    localparam int SY_REQ_N = 7;
    localparam int SY_CHAIN = 8;
    localparam int SY_INT_N = 9;
    localparam int SY_HS_DATA = 10;
    localparam int SY_BUS_DATA = 18;
    localparam int SY_W = 26;

    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_SETUP = 3'b001,
        HS_VALID = 3'b010,
        HS_RELEASE = 3'b011,
        HS_RX_READY = 3'b100,
        HS_RX_ACCEPT = 3'b101
    } hs_state_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_REQ = 3'b001,
        BUS_SETUP = 3'b010,
        BUS_STROBE = 3'b011,
        BUS_HOLD = 3'b100
    } bus_state_t;

endpackage

//--- sync_if.sv
// carrier between the host core and its pin synchroniser
`timescale 1ns/1ps
interface sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport core (output raw, input clean);
    modport sync (input raw, output clean);
endinterface

//--- pin_sync.sv
// three-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync (
    input wire logic clock,
    input wire logic rst,
    sync_if.sync port
);
    localparam int W = $bits(port.raw);

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic clean_r;
            logic clean_nxt;
            // a change counts only once the second and third stages agree
            always_comb begin
                clean_nxt = clean_r;
                if (s2_r == s3_r) begin
                    clean_nxt = s3_r;
                end
            end
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    clean_r <= 1'b0;
                end else begin
                    s1_r <= port.raw[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    clean_r <= clean_nxt;
                end
            end
            assign port.clean[i] = clean_r;
        end
    endgenerate
endmodule // pin_sync

//--- fifo_port_host_monitor.sv
// pin-level assertions for the fifo port host
`timescale 1ns/1ps
module fifo_port_host_monitor (
    input wire logic clock, rst, read_n, write_n, chip_enable_n, dma_grant_n,
    input wire logic control_select, hs_data_oe, output_enable_n,
    input wire logic valid_or_accepted_in, clear_n_oe, clear_n_out,
    input wire logic bus_data_oe,
    input wire logic [7:0] bus_data_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_strobes_apart: assert property (read_n || write_n)
        else $error("strobes overlap");
    a_write_selected: assert property (!write_n |-> !chip_enable_n || !dma_grant_n)
        else $error("write unselected");
    a_write_width: assert property ($fell(write_n) |-> !write_n [*8])
        else $error("write strobe short");
    a_wdata_held: assert property (!write_n |-> bus_data_oe && $stable(bus_data_out))
        else $error("write data moved");
    a_oe_apart: assert property (!output_enable_n |-> !hs_data_oe)
        else $error("both drive data");
    a_valid_setup: assert property ($rose(hs_data_oe) |-> ##2 !valid_or_accepted_in)
        else $error("valid late");
    a_clear_low: assert property (clear_n_oe |-> !clear_n_out)
        else $error("clear not low");
    a_select_held: assert property (!read_n || !write_n |-> $stable(control_select))
        else $error("select moved");
endmodule // fifo_port_host_monitor
bind fifo_port_host fifo_port_host_monitor fifo_port_host_monitor_inst (.*);

//--- fifo_device_model.sv
// behavioural fifo device at the far side of the host
`timescale 1ns/1ps
module fifo_device_model #(parameter logic [7:0] RD_BYTE = 8'hC3) (
    input wire logic clock, rst, valid_or_accepted_in, hs_data_oe, read_n,
    input wire logic [7:0] hs_data_out,
    input wire logic chip_enable_n, chain_enable_in, clear_n_oe, clear_n_out,
    input wire logic data_dir_oe, data_dir_out,
    input wire logic dma_grant_n, irq_acknowledge_n,
    output logic ready_or_available_out, accepted_or_listener_ready_in,
    output logic empty, clear_n_in, data_dir_in, req_wait_n, irq_n,
    output logic gp_output_bit1, gp_output_bit3, chain_enable_out,
    output logic [7:0] bus_data_in, hs_data_in, got_r
);
    assign ready_or_available_out = 1'b1; // always room
    assign empty = 1'b1;
    assign clear_n_in = clear_n_oe ? clear_n_out : 1'b1; // pull-up
    assign data_dir_in = data_dir_oe ? data_dir_out : 1'b1;
    // dma request stands while no cpu or acknowledge cycle is selected
    assign req_wait_n = !(chip_enable_n && irq_acknowledge_n);
    assign irq_n = 1'b1;
    assign chain_enable_out = chain_enable_in; // idle
    assign gp_output_bit1 = 1'b0;
    assign gp_output_bit3 = 1'b1;
    assign hs_data_in = ~got_r; // not enabled, so no stale byte
    // deselected lines show the inverse so a late sample is caught
    assign bus_data_in = (!read_n && (!chip_enable_n || !dma_grant_n
                         || !irq_acknowledge_n)) ? RD_BYTE : ~RD_BYTE;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            accepted_or_listener_ready_in <= 1'b0;
            got_r <= 8'h00;
        end else if (!valid_or_accepted_in && hs_data_oe) begin
            accepted_or_listener_ready_in <= 1'b1;
            got_r <= hs_data_out;
        end else if (valid_or_accepted_in) begin
            accepted_or_listener_ready_in <= 1'b0;
        end
    end
endmodule // fifo_device_model

//--- fifo_port_host_tb.sv
// self-checking bench for the fifo port host
`timescale 1ns/1ps
module fifo_port_host_tb;
    logic clock = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [2:0] avs_address = 3'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, hs_data_oe, output_enable_n, ready_or_available_out;
    logic valid_or_accepted_in, accepted_or_listener_ready_in, empty;
    logic accepted_or_listener_ready_out, accepted_or_listener_ready_oe;
    logic clear_n_in, clear_n_out, clear_n_oe, data_dir_in, data_dir_out;
    logic data_dir_oe, gp_input_bit0, gp_output_bit1, gp_output_bit3, irq_n;
    logic bus_data_oe, req_wait_n, dma_grant_n, read_n, write_n;
    logic chip_enable_n, control_select, irq_acknowledge_n, chain_enable_in;
    logic chain_enable_out;
    logic [7:0] hs_data_in, hs_data_out, bus_data_in, bus_data_out, got_r;
    int err_count = 0, n_checks = 0;
    fifo_port_host fifo_port_host_inst (.*);
    fifo_device_model fifo_device_model_inst (.*);
    always #5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    task automatic acc(input logic [2:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        // request stands until the edge at which waitrequest is seen low
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // bounded wait for a status bit to clear
    task automatic poll(input int b);
        repeat (100) begin
            acc(fifo_host_pkg::REG_STATUS, 1'b0, 32'h0);
            if (q[b] === 1'b0) return;
        end
        chk(q, 32'h0);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        acc(fifo_host_pkg::REG_CTRL, 1'b0, 32'h0);
        chk(q, 32'h20);
        acc(fifo_host_pkg::REG_CTRL, 1'b1, 32'h0F);
        acc(fifo_host_pkg::REG_CTRL, 1'b0, 32'h0);
        chk(q, 32'h07);
        acc(fifo_host_pkg::REG_TX, 1'b1, 32'h5A);
        poll(fifo_host_pkg::ST_TX_BUSY);
        chk({24'h0, got_r}, 32'h5A);
        acc(fifo_host_pkg::REG_BUS_CMD, 1'b1, 32'h300);
        poll(fifo_host_pkg::ST_BUS_BUSY);
        acc(fifo_host_pkg::REG_BUS_RDATA, 1'b0, 32'h0);
        chk(q, 32'hC3);
        acc(fifo_host_pkg::REG_BUS_CMD, 1'b1, 32'h500);
        poll(fifo_host_pkg::ST_BUS_BUSY);
        acc(fifo_host_pkg::REG_BUS_RDATA, 1'b0, 32'h0);
        chk(q, 32'hC3);
        acc(fifo_host_pkg::REG_BUS_CMD, 1'b1, 32'h800);
        poll(fifo_host_pkg::ST_BUS_BUSY);
        acc(fifo_host_pkg::REG_BUS_RDATA, 1'b0, 32'h0);
        chk(q, 32'hC3);
        acc(fifo_host_pkg::REG_BUS_CMD, 1'b1, 32'hA5);
        poll(fifo_host_pkg::ST_BUS_BUSY);
        acc(fifo_host_pkg::REG_CTRL, 1'b1, 32'h0);
        repeat (8) @(posedge clock);
        acc(fifo_host_pkg::REG_STATUS, 1'b0, 32'h0);
        chk(q, 32'h05C);
        acc(3'h7, 1'b0, 32'h0);
        chk(q, 32'h0);
        close_out;
    end
    // the whole sequence needs under two hundred cycles
    initial begin
        #100000;
        err_count++;
        close_out;
    end
endmodule // fifo_port_host_tb
